// file: verilog/dfr_defs.vh
// Constants for the diagnostic flag register bank
`ifndef DFR_DEFS_VH
`define DFR_DEFS_VH

// Register byte offsets
`define DFR_OFS_CAUTION 8'h26
`define DFR_OFS_TEMP 8'h28
`define DFR_OFS_FIELD 8'h2A

// Register tag values in bits 15:12
`define DFR_TAG_CAUTION 4'hB
`define DFR_TAG_TEMP 4'hF
`define DFR_TAG_FIELD 4'hE

// Fault register bit positions held here
`define DFR_F_RESET 0
`define DFR_F_FLD_LO 1
`define DFR_F_ASUP_LO 2
`define DFR_F_SUMMARY 11

// Caution register bit positions
`define DFR_C_TOV 0
`define DFR_C_FLD_HI 1
`define DFR_C_OVERRUN 2
`define DFR_C_TSTEP 3
`define DFR_C_CLIP 4
`define DFR_C_SOFTERR 5
`define DFR_C_TEMP 6
`define DFR_C_XFAIL 7
`define DFR_C_SLEW 8
`define DFR_C_CRC 10
`define DFR_C_IFACE 11

// Reset values of the latched groups
`define DFR_FAULT_RST 3'h1
`define DFR_CAUT_RST 12'h000

// Default field limits in gauss
`define DFR_FLD_LO_DEF 12'h0C8
`define DFR_FLD_HI_DEF 12'h4B0

// Temperature limits in eighth degrees about 25 C
`define DFR_TEMP_MIN 16'hFD58
`define DFR_TEMP_MAX 16'h04D8

// Turn step limit: 135 deg in 4096 counts per turn
`define DFR_STEP_LIM 12'h600
`define DFR_HALF_TURN 12'h800

// Serial packet lengths without and with CRC
`define DFR_PKT_BITS 6'h10
`define DFR_PKT_BITS_CRC 6'h14

// Field refresh period and clock rate
`define DFR_FIELD_US 128
`define DFR_CLK_MHZ 50

`endif

// file: verilog/dfr_sticky.v
// Bank of sticky flags where a set wins over a clear
module dfr_sticky #(
    parameter W = 12,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input wire clk_i,
    input wire resetn_i,
    input wire [W-1:0] set_i,
    input wire [W-1:0] clr_i,
    output wire [W-1:0] flag_o
);
    reg [W-1:0] flag_r;
    genvar i;

    // One latch per bit; a set in the clear cycle survives
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    flag_r[i] <= RST[i];
                end else if (set_i[i]) begin
                    flag_r[i] <= 1'b1;
                end else if (clr_i[i]) begin
                    flag_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flag_o = flag_r;
endmodule

// file: verilog/dfr_tick.v
// Free running divider giving a one-cycle enable pulse
module dfr_tick #(
    parameter PERIOD = 6400
) (
    input wire clk_i,
    input wire resetn_i,
    output reg tick_o
);
    reg [15:0] cnt_r;

    // Count down; pulse on wrap
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_r == 16'h0000) begin
            cnt_r <= PERIOD[15:0] - 16'h0001;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 16'h0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// file: verilog/dfr_diag_regs.v
// Diagnostic fault, caution, temperature and field registers
`include "dfr_defs.vh"

module dfr_diag_regs #(
    parameter FIELD_TICK_CYC = `DFR_FIELD_US * `DFR_CLK_MHZ
) (
    input wire clk_i,
    input wire resetn_i,
    // Register read port
    input wire rd_en_i,
    input wire [7:0] rd_addr_i,
    output reg [15:0] rd_data_o,
    output reg rd_valid_o,
    output reg rd_hit_o,
    // Clear strobes from the host path
    input wire clr_fault_i,
    input wire clr_caution_i,
    input wire turns_reset_i,
    // Nonvolatile configuration
    input wire spi_crc_check_enable_i,
    input wire [11:0] field_low_limit_i,
    input wire [11:0] field_high_limit_i,
    input wire [2:0] fault_mask_i,
    input wire [11:0] caution_mask_i,
    input wire summary_mask_i,
    // Analog monitors
    input wire analog_supply_low_i,
    // Serial packet checks
    input wire pkt_done_i,
    input wire [5:0] pkt_bits_i,
    input wire pkt_msb_i,
    input wire pkt_crc_ok_i,
    input wire manchester_err_i,
    output reg pkt_accept_o,
    output reg pkt_discard_o,
    // Quadrature output slew limiter
    input wire slew_limit_en_i,
    input wire slew_needed_i,
    output reg slew_step_en_o,
    // Extended access and commands
    input wire xacc_start_i,
    input wire xacc_busy_i,
    input wire xcmd_done_i,
    input wire unlocked_i,
    input wire nvm_write_fail_i,
    // Memory load checks
    input wire nvm_loading_i,
    input wire ecc_corrected_i,
    // Measurement chain
    input wire [7:0] chain_sat_i,
    input wire temp_valid_i,
    input wire [15:0] temp_raw_i,
    input wire [11:0] field_gauss_i,
    input wire zcd_valid_i,
    input wire [11:0] zcd_angle_i,
    input wire turns_overflow_i,
    // Status outputs
    output reg [15:0] fault_low_o,
    output reg any_fault_flag_o
);
    // Latched flag groups
    wire [2:0] fault_w;
    wire [11:0] caut_w;
    reg [2:0] fault_set;
    reg [2:0] fault_clr;
    reg [11:0] caut_set;
    reg [11:0] caut_clr;

    // Measurement holding registers
    reg [11:0] temp_r;
    reg temp_oor_r;
    reg [11:0] field_r;
    reg [11:0] zcd_prev_r;
    reg zcd_seen_r;

    // Field refresh enable
    wire field_tick;

    // Derived conditions
    reg [5:0] pkt_len_exp;
    reg pkt_len_bad;
    reg pkt_iface_bad;
    reg pkt_crc_bad;
    reg [11:0] step_raw;
    reg [11:0] step_abs;
    reg step_big;
    reg temp_lo;
    reg temp_hi;
    reg [11:0] temp_nxt;
    reg fld_lo;
    reg fld_hi;
    reg summary;
    reg any_nxt;
    reg [15:0] rd_nxt;
    reg hit_nxt;
    wire [11:0] caut_unmasked;
    wire [2:0] fault_unmasked;

    // Limits as signed words; the register keeps the low twelve bits
    localparam [15:0] TEMP_MIN_W = `DFR_TEMP_MIN;
    localparam [15:0] TEMP_MAX_W = `DFR_TEMP_MAX;

    // Field refresh tick; its period sets the 128 us update
    dfr_tick #(
        .PERIOD(FIELD_TICK_CYC)
    ) u_tick (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tick_o(field_tick)
    );

    // Fault bits reset to 1 on bit 0: the reset marker
    dfr_sticky #(
        .W(3),
        .RST(`DFR_FAULT_RST)
    ) u_fault (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(fault_set),
        .clr_i(fault_clr),
        .flag_o(fault_w)
    );

    // Caution bank; bit 9 is reserved and never set
    dfr_sticky #(
        .W(12),
        .RST(`DFR_CAUT_RST)
    ) u_caution (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .set_i(caut_set),
        .clr_i(caut_clr),
        .flag_o(caut_w)
    );

    // Packet checks; the expected length grows with the CRC
    always @* begin
        if (spi_crc_check_enable_i) begin
            pkt_len_exp = `DFR_PKT_BITS_CRC;
        end else begin
            pkt_len_exp = `DFR_PKT_BITS;
        end
        pkt_len_bad = (pkt_bits_i != pkt_len_exp);
        pkt_iface_bad = pkt_len_bad | pkt_msb_i;
        // CRC is only judged on an otherwise sound packet
        pkt_crc_bad = spi_crc_check_enable_i & ~pkt_iface_bad
                      & ~manchester_err_i
                      & ~pkt_crc_ok_i;
    end

    // Shortest angular distance between turn samples
    // A wrap through zero counts as a short step, not a jump
    always @* begin
        step_raw = zcd_angle_i - zcd_prev_r;
        if (step_raw > `DFR_HALF_TURN) begin
            step_abs = 12'h000 - step_raw;
        end else begin
            step_abs = step_raw;
        end
        step_big = zcd_seen_r & (step_abs > `DFR_STEP_LIM);
    end

    // Temperature saturation at the range limits
    always @* begin
        // Range test on the full signed word before truncation
        temp_lo = $signed(temp_raw_i) < $signed(TEMP_MIN_W);
        temp_hi = $signed(temp_raw_i) > $signed(TEMP_MAX_W);
        if (temp_lo) begin
            temp_nxt = TEMP_MIN_W[11:0];
        end else if (temp_hi) begin
            temp_nxt = TEMP_MAX_W[11:0];
        end else begin
            temp_nxt = temp_raw_i[11:0];
        end
    end

    // Field limits judged on the refreshed sample
    always @* begin
        fld_lo = field_tick & (field_gauss_i < field_low_limit_i);
        fld_hi = field_tick & (field_gauss_i > field_high_limit_i);
    end

    // Fault set terms; reset marker is set only by reset itself
    always @* begin
        fault_set = 3'h0;
        // Supply low is a level, so it sets again while it lasts
        fault_set[`DFR_F_ASUP_LO] = analog_supply_low_i;
        fault_set[`DFR_F_FLD_LO] = fld_lo;
        fault_set[`DFR_F_RESET] = 1'b0;
        // One strobe clears all three fault bits
        fault_clr = {3{clr_fault_i}};
    end

    // Caution set terms, each a condition seen this cycle
    always @* begin
        caut_set = 12'h000;
        caut_set[`DFR_C_IFACE] = pkt_done_i
            & (pkt_iface_bad | manchester_err_i);
        caut_set[`DFR_C_CRC] = pkt_done_i & pkt_crc_bad;
        caut_set[`DFR_C_SLEW] = slew_limit_en_i
            & slew_needed_i;
        caut_set[`DFR_C_XFAIL] = xcmd_done_i
            & (~unlocked_i | nvm_write_fail_i);
        caut_set[`DFR_C_TEMP] = temp_valid_i
            & (temp_lo | temp_hi);
        caut_set[`DFR_C_SOFTERR] = nvm_loading_i
            & ecc_corrected_i;
        caut_set[`DFR_C_CLIP] = |chain_sat_i;
        caut_set[`DFR_C_TSTEP] = zcd_valid_i & step_big;
        caut_set[`DFR_C_OVERRUN] = xacc_start_i
            & xacc_busy_i;
        caut_set[`DFR_C_FLD_HI] = fld_hi;
        // Turns overflow has its own clear strobe below
        caut_set[`DFR_C_TOV] = turns_overflow_i;
    end

    // Clears; a persisting condition wins over them
    always @* begin
        caut_clr = {12{clr_caution_i}};
        caut_clr[`DFR_C_TOV] = turns_reset_i;
    end

    // Summary terms seen through the masks
    // Masks act on summaries only; latched bits stay readable
    assign caut_unmasked = caut_w & ~caution_mask_i;
    assign fault_unmasked = fault_w & ~fault_mask_i;

    always @* begin
        summary = ~summary_mask_i & (|caut_unmasked);
        any_nxt = (|fault_unmasked) | (|caut_unmasked);
    end

    // Measurement registers
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_r <= 12'h000;
            field_r <= 12'h000;
            zcd_prev_r <= 12'h000;
            zcd_seen_r <= 1'b0;
        end else begin
            // Temperature holds its last sample between updates
            if (temp_valid_i) begin
                temp_r <= temp_nxt;
            end
            // Sampling only on the tick keeps readings steady
            if (field_tick) begin
                field_r <= field_gauss_i;
            end
            // First sample after reset has nothing to compare
            if (zcd_valid_i) begin
                zcd_prev_r <= zcd_angle_i;
                zcd_seen_r <= 1'b1;
            end
        end
    end

    // Read multiplexer, plain if chain on the byte offset
    always @* begin
        // Unmapped offsets read zero with the hit flag low
        hit_nxt = 1'b1;
        if (rd_addr_i == `DFR_OFS_CAUTION) begin
            rd_nxt = {`DFR_TAG_CAUTION, caut_w};
        end else if (rd_addr_i == `DFR_OFS_TEMP) begin
            rd_nxt = {`DFR_TAG_TEMP, temp_r};
        end else if (rd_addr_i == `DFR_OFS_FIELD) begin
            rd_nxt = {`DFR_TAG_FIELD, field_r};
        end else begin
            rd_nxt = 16'h0000;
            hit_nxt = 1'b0;
        end
    end

    // Registered read answer, one cycle after the request
    // Data holds between reads so a slow host sees it steady
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= 16'h0000;
            rd_valid_o <= 1'b0;
            rd_hit_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= rd_nxt;
                rd_hit_o <= hit_nxt;
            end
        end
    end

    // Packet verdict, a pulse one cycle after the packet ends
    // Accept and discard never pulse for the same packet
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pkt_accept_o <= 1'b0;
            pkt_discard_o <= 1'b0;
        end else begin
            pkt_accept_o <= pkt_done_i & ~pkt_iface_bad
                & ~manchester_err_i & ~pkt_crc_bad;
            pkt_discard_o <= pkt_done_i & (pkt_iface_bad
                | manchester_err_i | pkt_crc_bad);
        end
    end

    // Slew step enable follows the live limiting condition
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            slew_step_en_o <= 1'b0;
        end else begin
            slew_step_en_o <= slew_limit_en_i & slew_needed_i;
        end
    end

    // Fault word low part and the any-fault flag
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_low_o <= 16'h0000;
            any_fault_flag_o <= 1'b0;
        end else begin
            fault_low_o <= {4'h0, summary, 8'h00, fault_w};
            any_fault_flag_o <= any_nxt;
        end
    end
endmodule

// file: testbench/dfr_diag_regs_props.sv
// Port level assertions for the diagnostic register bank
module dfr_diag_regs_props (
    input wire clk_i,
    input wire resetn_i,
    input wire rd_en_i,
    input wire [7:0] rd_addr_i,
    input wire [15:0] rd_data_o,
    input wire rd_valid_o,
    input wire rd_hit_o,
    input wire analog_supply_low_i,
    input wire pkt_done_i,
    input wire [5:0] pkt_bits_i,
    input wire pkt_msb_i,
    input wire pkt_crc_ok_i,
    input wire manchester_err_i,
    input wire spi_crc_check_enable_i,
    input wire pkt_accept_o,
    input wire pkt_discard_o,
    input wire slew_limit_en_i,
    input wire slew_needed_i,
    input wire slew_step_en_o,
    input wire [2:0] fault_mask_i,
    input wire [15:0] fault_low_o,
    input wire any_fault_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rd_answer;
        rd_en_i |=> rd_valid_o;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rd_quiet;
        !rd_en_i |=> !rd_valid_o;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read answer without request");
    property p_tag_caution;
        rd_en_i && rd_addr_i == 8'h26 |=> rd_hit_o && rd_data_o[15:12] == 4'hB;
    endproperty
    a_tag_caution: assert property (p_tag_caution)
        else $error("caution tag wrong");
    property p_tag_temp;
        rd_en_i && rd_addr_i == 8'h28 |=> rd_hit_o && rd_data_o[15:12] == 4'hF;
    endproperty
    a_tag_temp: assert property (p_tag_temp)
        else $error("temperature tag wrong");
    property p_tag_field;
        rd_en_i && rd_addr_i == 8'h2A |=> rd_hit_o && rd_data_o[15:12] == 4'hE;
    endproperty
    a_tag_field: assert property (p_tag_field)
        else $error("field tag wrong");
    property p_asup;
        analog_supply_low_i |-> ##2 fault_low_o[2];
    endproperty
    a_asup: assert property (p_asup)
        else $error("supply low not flagged");
    property p_iface;
        pkt_done_i && pkt_msb_i |=> pkt_discard_o && !pkt_accept_o;
    endproperty
    a_iface: assert property (p_iface)
        else $error("packet with top bit set kept");
    property p_crc;
        pkt_done_i && spi_crc_check_enable_i && pkt_bits_i == 6'h14
            && !pkt_msb_i && !manchester_err_i && !pkt_crc_ok_i
            |=> pkt_discard_o;
    endproperty
    a_crc: assert property (p_crc)
        else $error("bad check sum kept");
    property p_slew;
        slew_limit_en_i && slew_needed_i |=> slew_step_en_o;
    endproperty
    a_slew: assert property (p_slew)
        else $error("slew limiting not engaged");
    // Flag is registered, so it follows last cycle's mask
    property p_any;
        |(fault_low_o[2:0] & ~$past(fault_mask_i)) |-> any_fault_flag_o;
    endproperty
    a_any: assert property (p_any)
        else $error("any fault flag low with fault set");
endmodule

bind dfr_diag_regs dfr_diag_regs_props u_props (.*);

// file: testbench/dfr_host_model.sv
// Host side model issuing register reads and clear strobes
module dfr_host_model (
    input wire clk_i,
    input wire req_i,
    input wire [7:0] addr_i,
    input wire [2:0] clr_i,
    output logic rd_en_o,
    output logic [7:0] rd_addr_o,
    output logic [2:0] clr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Requests leave one edge after the bench asks; idle address scrambled
    always @(posedge clk_i) begin
        rd_en_o <= req_i;
        rd_addr_o <= req_i ? addr_i : ~rd_addr_o;
        clr_o <= clr_i;
    end
endmodule

// file: testbench/dfr_diag_regs_tb_top.sv
// Self-checking bench for the diagnostic register bank
module dfr_diag_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, resetn_i = 0, req = 0;
    logic [7:0] addr = 8'h00, rd_addr_i;
    logic [2:0] clr = 3'h0;
    logic rd_en_i, clr_fault_i, clr_caution_i, turns_reset_i;
    logic spi_crc_check_enable_i = 0, analog_supply_low_i = 0;
    logic [11:0] field_low_limit_i = 12'h0C8, field_high_limit_i = 12'h4B0;
    logic [2:0] fault_mask_i = 3'h0;
    logic [11:0] caution_mask_i = 12'h000;
    logic summary_mask_i = 0, pkt_done_i = 0, pkt_msb_i = 0;
    logic [5:0] pkt_bits_i = 6'h10;
    logic pkt_crc_ok_i = 1, manchester_err_i = 0, slew_limit_en_i = 0;
    logic slew_needed_i = 0, xacc_start_i = 0, xacc_busy_i = 0;
    logic xcmd_done_i = 0, unlocked_i = 0, nvm_write_fail_i = 0;
    logic nvm_loading_i = 0, ecc_corrected_i = 0, temp_valid_i = 0;
    logic [7:0] chain_sat_i = 8'h00;
    logic [15:0] temp_raw_i = 16'h0000, rd_data_o, fault_low_o;
    logic [11:0] field_gauss_i = 12'h180, zcd_angle_i = 12'h000;
    logic zcd_valid_i = 0, turns_overflow_i = 0, any_fault_flag_o;
    logic rd_valid_o, rd_hit_o, pkt_accept_o, pkt_discard_o, slew_step_en_o;
    wire [16:0] flags_seen = {any_fault_flag_o, fault_low_o};
    logic [16:0] exp_q[$];
    logic [31:0] seed = 32'h0000000B;
    int fails = 0, comparisons = 0;
    logic [9:0] pk [7] = '{10'h102, 10'h0F2, 10'h10A, 10'h103, 10'h144,
        10'h146, 10'h106};
    logic [11:0] pe [7] = '{12'h000, 12'h800, 12'h800, 12'h800, 12'h400,
        12'h000, 12'h800};
    logic [3:0] em [10] = '{4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1,
        4'h7, 4'h0};

    dfr_host_model host (.clk_i(clk_i), .req_i(req), .addr_i(addr),
        .clr_i(clr), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i),
        .clr_o({turns_reset_i, clr_caution_i, clr_fault_i}));
    dfr_diag_regs #(.FIELD_TICK_CYC(16)) dut (.*);

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic chk(input string n, input logic [16:0] e, s);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // Hit flag of the note follows from the address map
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back({a == 8'h26 || a == 8'h28 || a == 8'h2A, e});
        addr = a;
        req = 1;
        step();
        req = 0;
        step(3);
    endtask
    task automatic clrp(input logic [2:0] m);
        clr = m;
        step();
        clr = 0;
        step(4);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Read answers are matched against the oldest note, mid cycle
    always @(negedge clk_i) begin
        if (rd_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("ERROR read expected none seen %h", rd_data_o);
            end else begin
                chk("read", exp_q.pop_front(),
                    {rd_hit_o, rd_data_o});
            end
        end
    end

    // Watchdog sized well above the few hundred cycles of the run
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

    initial begin
        field_gauss_i = 12'h100 + 12'(xs() & 32'hFF);
        step(12);
        resetn_i = 1;
        step(2);
        chk("fault", 17'h10001, flags_seen);
        rd(8'h26, 16'hB000);
        rd(8'h2A, {4'hE, field_gauss_i});
        rd(8'h40, 16'h0000);
        clrp(3'h1);
        chk("fault", 17'h0, {any_fault_flag_o, fault_low_o});
        $display("test reset done");
        analog_supply_low_i = 1;
        step();
        analog_supply_low_i = 0;
        step(6);
        chk("fault", 17'h0004, fault_low_o);
        clrp(3'h1);
        field_gauss_i = 12'h050;
        step(20);
        field_gauss_i = 12'h200;
        step(20);
        chk("fault", 17'h0002, fault_low_o);
        clrp(3'h1);
        chk("fault", 17'h0, fault_low_o);
        $display("test fault flags done");
        for (int i = 0; i < 10; i++) begin
            case (i)
                0: begin
                    slew_limit_en_i = 1;
                    slew_needed_i = 1;
                    step(2);
                    chk("slew", 17'h1, slew_step_en_o);
                    slew_needed_i = 0;
                end
                1, 8: begin
                    unlocked_i = (i == 8);
                    nvm_write_fail_i = (i == 8);
                    xcmd_done_i = 1;
                    step();
                    xcmd_done_i = 0;
                end
                2: begin
                    temp_raw_i = 16'h0700;
                    temp_valid_i = 1;
                    step();
                    temp_valid_i = 0;
                    step(2);
                    rd(8'h28, 16'hF4D8);
                end
                3: begin
                    nvm_loading_i = 1;
                    ecc_corrected_i = 1;
                    step();
                    ecc_corrected_i = 0;
                    nvm_loading_i = 0;
                end
                4: begin
                    chain_sat_i = 8'h20;
                    step();
                    chain_sat_i = 8'h00;
                end
                5: begin
                    zcd_valid_i = 1;
                    step();
                    zcd_angle_i = 12'h700;
                    step();
                    zcd_valid_i = 0;
                end
                6: begin
                    xacc_busy_i = 1;
                    xacc_start_i = 1;
                    step();
                    xacc_start_i = 0;
                    xacc_busy_i = 0;
                end
                7: begin
                    field_gauss_i = 12'h500;
                    step(20);
                    field_gauss_i = 12'h200;
                end
                default: begin
                    turns_overflow_i = 1;
                    step();
                    turns_overflow_i = 0;
                end
            endcase
            step(3);
            chk("summary", 17'h10800, flags_seen);
            rd(8'h26, {4'hB, 12'h001 << em[i]});
            clrp(3'h2);
            rd(8'h26, {4'hB, (i == 9) ? 12'h001 : 12'h000});
        end
        clrp(3'h4);
        rd(8'h26, 16'hB000);
        chain_sat_i = 8'h01;
        step(2);
        clrp(3'h2);
        rd(8'h26, 16'hB010);
        chain_sat_i = 8'h00;
        clrp(3'h2);
        temp_raw_i = 16'hFF00 | 16'(xs() & 32'hFF);
        temp_valid_i = 1;
        step();
        temp_valid_i = 0;
        step(2);
        rd(8'h28, {4'hF, temp_raw_i[11:0]});
        $display("test caution flags done");
        for (int i = 0; i < 7; i++) begin
            {pkt_bits_i, pkt_msb_i, spi_crc_check_enable_i, pkt_crc_ok_i,
                manchester_err_i} = pk[i];
            pkt_done_i = 1;
            step();
            pkt_done_i = 0;
            chk("packet", {pe[i] != 0, pe[i] == 0},
                {pkt_discard_o, pkt_accept_o});
            rd(8'h26, {4'hB, pe[i]});
            clrp(3'h2);
        end
        $display("test packets done");
        caution_mask_i = 12'h010;
        chain_sat_i = 8'h01;
        step();
        chain_sat_i = 8'h00;
        step(3);
        chk("mask", 17'h00000, flags_seen);
        summary_mask_i = 1;
        caution_mask_i = 12'h000;
        step(2);
        chk("mask", 17'h10000, flags_seen);
        clrp(3'h2);
        summary_mask_i = 0;
        fault_mask_i = 3'h4;
        analog_supply_low_i = 1;
        step();
        analog_supply_low_i = 0;
        step(3);
        chk("mask", 17'h00004, flags_seen);
        fault_mask_i = 3'h0;
        clrp(3'h1);
        chk("mask", 17'h00000, flags_seen);
        $display("test masks done");
        step(5);
        if (exp_q.size() != 0) begin
            fails++;
            $display("ERROR read notes expected 0 seen %0d", exp_q.size());
        end
        report_and_stop();
    end
endmodule
